// file: shared/sbcr_pkg.sv
// Operation
// - restart entry clears software failure-output bit
// - soft reset keeps aux voltage, load-share bits
// - stop-off bit0: 0 runs, 1 stops watchdog only while the second stop-off bit is also 1
// - window select: 0 time-out, 1 window watchdog
// - bus wake in stop starts long window
// - period codes 10 to 1000 ms, 111 reserved
// - LIN fast-programming bit disables slope control
// - LIN low-slope bit selects 10.4 kBaud slope
// - LIN slope bits apply at select release
// - LIN transmit time-out supervision enable bit
// - LIN mode: off, wake, receive, normal
// - CAN mode low bits, top bit selective wake
// - device changes selective-wake bit itself only on fail-safe entry or soft reset
// - sleep entry without system error: normal becomes wake
// - receive-only: wake on sleep, kept on stop
// - wake capable or off stays unchanged
// - fail-safe forces bus and external wake values
// - peak threshold bit: 0 low, 1 high
// - peak bit writes ignored outside init, normal
// - reserved bits always read as zero
// - second stop-off bit in internal wake register
// - interrupt-global bit: wake only or all status
package sbcr_pkg;
  localparam logic [6:0] ADDR_HW_CONTROL = 7'h02;
  localparam logic [6:0] ADDR_WATCHDOG_CONTROL = 7'h03;
  localparam logic [6:0] ADDR_BUS_CONTROL_ONE = 7'h04;
  localparam logic [6:0] ADDR_BUS_CONTROL_TWO = 7'h05;
  localparam logic [6:0] ADDR_WAKE_INT_CONTROL = 7'h06;
  localparam logic [6:0] ADDR_WAKE_EXT_CONTROL = 7'h07;

  // writable bit masks; reserved positions are zero
  localparam logic [7:0] MASK_HW = 8'hfb;
  localparam logic [7:0] MASK_WD = 8'hf7;
  localparam logic [7:0] MASK_BUS1 = 8'hff;
  localparam logic [7:0] MASK_BUS2 = 8'h20;
  localparam logic [7:0] MASK_WKI = 8'hc4;
  localparam logic [7:0] MASK_WKE = 8'ha7;

  localparam logic [7:0] RST_HW = 8'h00;
  localparam logic [7:0] RST_WD = 8'h14;
  localparam logic [7:0] RST_BUS1 = 8'h20;
  localparam logic [7:0] RST_BUS2 = 8'h00;
  localparam logic [7:0] RST_WKI = 8'h00;
  localparam logic [7:0] RST_WKE = 8'h07;

  // soft reset keeps these hardware control bits
  localparam logic [7:0] HW_SOFT_KEEP = 8'h88;
  localparam int HW_FAILURE_OUTPUT_SW_ON = 5;
  localparam int WD_STOP_OFF0 = 6;
  localparam int WD_WINDOW = 5;
  localparam int WD_BUS_WAKE = 4;
  localparam int BUS1_LIN_FAST = 7;
  localparam int BUS1_LIN_LOW_SLOPE = 6;
  localparam int BUS1_LIN_TX_TIMEOUT_ENABLE = 5;
  localparam int BUS2_PEAK_TH = 5;
  localparam int WKI_STOP_OFF1 = 2;
  localparam int WKE_INT_GLOBAL = 7;

  // fail-safe values: bus mode low five bits, external wake forced bits
  localparam logic [4:0] FS_BUS1_LOW = 5'b01001;
  localparam logic [7:0] FS_WKE_KEEP = 8'ha0;
  localparam logic [7:0] FS_WKE_SET = 8'h07;

  localparam logic [1:0] XCVR_OFF = 2'b00;
  localparam logic [1:0] XCVR_WAKE = 2'b01;
  localparam logic [1:0] XCVR_RX_ONLY = 2'b10;
  localparam logic [1:0] XCVR_NORMAL = 2'b11;

  localparam logic [4:0] FRAME_BITS = 5'd16;
  localparam logic [4:0] ADDR_BITS = 5'd8;

  typedef enum logic [2:0] {
    SBCR_MODE_INIT = 3'b000,
    SBCR_MODE_NORMAL = 3'b001,
    SBCR_MODE_STOP = 3'b010,
    SBCR_MODE_SLEEP = 3'b011,
    SBCR_MODE_RESTART = 3'b100,
    SBCR_MODE_FAILSAFE = 3'b101
  } sbcr_mode_t;
endpackage

// file: design/sbcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module sbcr_regs
  import sbcr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // spi slave pins
  input wire logic spi_select_low,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  // device state and events
  input wire logic [2:0] dev_mode,
  input wire logic system_error_flag,
  input wire logic enter_sleep,
  input wire logic enter_stop,
  input wire logic enter_restart,
  input wire logic enter_failsafe,
  input wire logic soft_reset,
  input wire logic bus_wake_in_stop,
  // hardware control outputs
  output logic failure_outputs,
  output logic aux_reg_voltage_cfg,
  output logic aux_reg_load_share,
  output logic aux_load_share_stop_on,
  // watchdog configuration
  output logic wdog_window_select,
  output logic wdog_start_on_bus_wake,
  output logic [2:0] wdog_period,
  output logic wdog_stop_off,
  output logic wdog_long_open_start,
  // bus configuration
  output logic lin_fast_prog,
  output logic lin_low_slope,
  output logic lin_tx_timeout_enable,
  output logic [1:0] lin_mode_field,
  output logic [2:0] can_mode,
  output logic main_reg_peak_threshold,
  output logic int_global
);

  typedef struct packed {
    logic [7:0] hw;
    logic [7:0] wd;
    logic [7:0] bus1;
    logic [7:0] bus2;
    logic [7:0] wki;
    logic [7:0] wke;
    logic sclk_q;
    logic sel_q;
    logic [4:0] cnt;
    logic [15:0] rx;
    logic [7:0] tx;
    logic miso;
    logic long_start;
    logic stop_off;
  } sbcr_state_t;

  sbcr_state_t st;
  sbcr_state_t next_st;

  function automatic logic [7:0] reg_read(input sbcr_state_t s, input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ADDR_HW_CONTROL: v = s.hw & MASK_HW;
      ADDR_WATCHDOG_CONTROL: v = s.wd & MASK_WD;
      ADDR_BUS_CONTROL_ONE: v = s.bus1 & MASK_BUS1;
      ADDR_BUS_CONTROL_TWO: v = s.bus2 & MASK_BUS2;
      ADDR_WAKE_INT_CONTROL: v = s.wki & MASK_WKI;
      ADDR_WAKE_EXT_CONTROL: v = s.wke & MASK_WKE;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // merge write data into writable positions only
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] d,
                                       input logic [7:0] m);
    return (old & ~m) | (d & m);
  endfunction

  logic sclk_rise;
  logic sclk_fall;
  logic frame_end;
  logic wr_ok;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic peak_writable;

  assign sclk_rise = !spi_select_low && spi_sclk && !st.sclk_q;
  assign sclk_fall = !spi_select_low && !spi_sclk && st.sclk_q;
  assign frame_end = spi_select_low && !st.sel_q;
  assign wr_ok = frame_end && (st.cnt == FRAME_BITS) && st.rx[15];
  assign wr_addr = st.rx[14:8];
  assign wr_data = st.rx[7:0];
  assign peak_writable = (dev_mode == SBCR_MODE_INIT) || (dev_mode == SBCR_MODE_NORMAL);

  always_comb begin
    next_st = st;
    next_st.sclk_q = spi_sclk;
    next_st.sel_q = spi_select_low;
    next_st.long_start = 1'b0;

    // serial shifter: sample on rising, drive on falling edge
    if (spi_select_low) begin
      next_st.cnt = 5'd0;
      next_st.miso = 1'b0;
    end else if (sclk_rise) begin
      next_st.rx = {st.rx[14:0], spi_mosi};
      if (st.cnt != FRAME_BITS) begin
        next_st.cnt = st.cnt + 5'd1;
      end
      if (st.cnt == ADDR_BITS - 5'd1) begin
        next_st.tx = reg_read(st, {st.rx[5:0], spi_mosi});
      end
    end else if (sclk_fall && st.cnt >= ADDR_BITS) begin
      next_st.miso = st.tx[7];
      next_st.tx = {st.tx[6:0], 1'b0};
    end

    // writes land when select returns high, so slope bits switch then
    if (wr_ok) begin
      case (wr_addr)
        ADDR_HW_CONTROL: next_st.hw = merge(st.hw, wr_data, MASK_HW);
        ADDR_WATCHDOG_CONTROL: next_st.wd = merge(st.wd, wr_data, MASK_WD);
        ADDR_BUS_CONTROL_ONE: next_st.bus1 = merge(st.bus1, wr_data, MASK_BUS1);
        ADDR_BUS_CONTROL_TWO: begin
          if (peak_writable) begin
            next_st.bus2 = merge(st.bus2, wr_data, MASK_BUS2);
          end
        end
        ADDR_WAKE_INT_CONTROL: next_st.wki = merge(st.wki, wr_data, MASK_WKI);
        ADDR_WAKE_EXT_CONTROL: next_st.wke = merge(st.wke, wr_data, MASK_WKE);
        default: next_st.hw = next_st.hw;
      endcase
    end

    // mode entry side effects override a coincident write
    if (enter_restart) begin
      next_st.hw[HW_FAILURE_OUTPUT_SW_ON] = 1'b0;
    end
    if (enter_sleep && !system_error_flag && next_st.bus1[1]) begin
      next_st.bus1[1:0] = XCVR_WAKE;
    end
    // stop entry keeps receive-only; wake and off are never touched
    if (enter_stop) begin
      next_st.bus1[1:0] = next_st.bus1[1:0];
    end
    if (enter_failsafe) begin
      next_st.bus1[4:0] = FS_BUS1_LOW;
      next_st.wke = (next_st.wke & FS_WKE_KEEP) | FS_WKE_SET;
    end
    if (soft_reset) begin
      next_st.hw = st.hw & HW_SOFT_KEEP;
      next_st.wd = RST_WD;
      next_st.bus1 = RST_BUS1;
      next_st.bus2 = RST_BUS2;
      next_st.wki = RST_WKI;
      next_st.wke = RST_WKE;
    end

    if (bus_wake_in_stop && st.wd[WD_BUS_WAKE]) begin
      next_st.long_start = 1'b1;
    end
    // both stop-off bits must be 1 before the watchdog stops
    next_st.stop_off = next_st.wd[WD_STOP_OFF0] && next_st.wki[WKI_STOP_OFF1];
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{hw: RST_HW, wd: RST_WD, bus1: RST_BUS1, bus2: RST_BUS2, wki: RST_WKI,
              wke: RST_WKE, sclk_q: 1'b0, sel_q: 1'b1, cnt: 5'd0, rx: 16'h0000,
              tx: 8'h00, miso: 1'b0, long_start: 1'b0, stop_off: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign spi_miso = st.miso;
  assign failure_outputs = st.hw[HW_FAILURE_OUTPUT_SW_ON];
  assign aux_reg_voltage_cfg = st.hw[7];
  assign aux_reg_load_share = st.hw[3];
  assign aux_load_share_stop_on = st.hw[1];
  assign wdog_window_select = st.wd[WD_WINDOW];
  assign wdog_start_on_bus_wake = st.wd[WD_BUS_WAKE];
  assign wdog_period = st.wd[2:0];
  assign wdog_stop_off = st.stop_off;
  assign wdog_long_open_start = st.long_start;
  assign lin_fast_prog = st.bus1[BUS1_LIN_FAST];
  assign lin_low_slope = st.bus1[BUS1_LIN_LOW_SLOPE];
  assign lin_tx_timeout_enable = st.bus1[BUS1_LIN_TX_TIMEOUT_ENABLE];
  assign lin_mode_field = st.bus1[4:3];
  assign can_mode = st.bus1[2:0];
  assign main_reg_peak_threshold = st.bus2[BUS2_PEAK_TH];
  assign int_global = st.wke[WKE_INT_GLOBAL];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_restart_fo;
    enter_restart && !soft_reset |=> !failure_outputs;
  endproperty
  a_restart_fo: assert property (p_restart_fo) else $error("fo bit not cleared");

  property p_soft_keep;
    soft_reset |=> aux_reg_voltage_cfg == $past(aux_reg_voltage_cfg)
      && aux_reg_load_share == $past(aux_reg_load_share) && !failure_outputs
      && !aux_load_share_stop_on;
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("soft reset aux bits");

  property p_stop_off;
    wdog_stop_off == (st.wd[WD_STOP_OFF0] && st.wki[WKI_STOP_OFF1]);
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("stop-off mismatch");

  property p_bus_wake;
    bus_wake_in_stop && wdog_start_on_bus_wake |=> wdog_long_open_start ##1 !wdog_long_open_start
      or bus_wake_in_stop;
  endproperty
  a_bus_wake: assert property (p_bus_wake) else $error("long window start");

  property p_sleep_can;
    enter_sleep && !system_error_flag && can_mode[1] && !soft_reset && !enter_failsafe
      && !wr_ok |=> can_mode[1:0] == XCVR_WAKE && can_mode[2] == $past(can_mode[2]);
  endproperty
  a_sleep_can: assert property (p_sleep_can) else $error("sleep can mode");

  property p_stop_keep;
    enter_stop && !enter_sleep && !soft_reset && !enter_failsafe && !wr_ok
      |=> can_mode == $past(can_mode);
  endproperty
  a_stop_keep: assert property (p_stop_keep) else $error("stop changed can");

  property p_failsafe;
    enter_failsafe && !soft_reset |=> can_mode == 3'b001 && lin_mode_field == XCVR_WAKE
      && st.wke[2:0] == 3'b111 && !st.wke[6] && !st.wke[4];
  endproperty
  a_failsafe: assert property (p_failsafe) else $error("fail-safe values");

  property p_peak_lock;
    !peak_writable && !soft_reset |=> main_reg_peak_threshold == $past(main_reg_peak_threshold);
  endproperty
  a_peak_lock: assert property (p_peak_lock) else $error("peak bit changed");

  property p_reserved;
    (st.wd[3] == 1'b0) && ((st.bus2 & ~MASK_BUS2) == 8'h00) && (st.hw[2] == 1'b0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_fo_write;
    wr_ok && wr_addr == ADDR_HW_CONTROL && !enter_restart && !soft_reset
      |=> failure_outputs == $past(wr_data[HW_FAILURE_OUTPUT_SW_ON]);
  endproperty
  a_fo_write: assert property (p_fo_write) else $error("fo bit not written");

  property p_wd_stop_bit;
    wr_ok && wr_addr == ADDR_WATCHDOG_CONTROL && !soft_reset
      |=> st.wd[WD_STOP_OFF0] == $past(wr_data[WD_STOP_OFF0]);
  endproperty
  a_wd_stop_bit: assert property (p_wd_stop_bit) else $error("stop-off bit lost");

  property p_window;
    wr_ok && wr_addr == ADDR_WATCHDOG_CONTROL && !soft_reset
      |=> wdog_window_select == $past(wr_data[WD_WINDOW]);
  endproperty
  a_window: assert property (p_window) else $error("window select lost");

  property p_bus_wake_en;
    wr_ok && wr_addr == ADDR_WATCHDOG_CONTROL && !soft_reset
      |=> wdog_start_on_bus_wake == $past(wr_data[WD_BUS_WAKE]);
  endproperty
  a_bus_wake_en: assert property (p_bus_wake_en) else $error("bus wake enable lost");

  property p_long_idle;
    !(bus_wake_in_stop && wdog_start_on_bus_wake) |=> !wdog_long_open_start;
  endproperty
  a_long_idle: assert property (p_long_idle) else $error("spurious long window");

  property p_period;
    wr_ok && wr_addr == ADDR_WATCHDOG_CONTROL && !soft_reset
      |=> wdog_period == $past(wr_data[2:0]);
  endproperty
  a_period: assert property (p_period) else $error("period code lost");

  property p_lin_slope;
    wr_ok && wr_addr == ADDR_BUS_CONTROL_ONE && !soft_reset
      |=> lin_fast_prog == $past(wr_data[BUS1_LIN_FAST])
      && lin_low_slope == $past(wr_data[BUS1_LIN_LOW_SLOPE]);
  endproperty
  a_lin_slope: assert property (p_lin_slope) else $error("slope bits late");

  property p_lin_txd;
    wr_ok && wr_addr == ADDR_BUS_CONTROL_ONE && !soft_reset
      |=> lin_tx_timeout_enable == $past(wr_data[BUS1_LIN_TX_TIMEOUT_ENABLE]);
  endproperty
  a_lin_txd: assert property (p_lin_txd) else $error("txd time-out bit lost");

  property p_lin_mode;
    wr_ok && wr_addr == ADDR_BUS_CONTROL_ONE && !soft_reset && !enter_failsafe
      |=> lin_mode_field == $past(wr_data[4:3]);
  endproperty
  a_lin_mode: assert property (p_lin_mode) else $error("lin mode lost");

  property p_can_sel_wake;
    !soft_reset && !enter_failsafe && !(wr_ok && wr_addr == ADDR_BUS_CONTROL_ONE)
      |=> can_mode[2] == $past(can_mode[2]);
  endproperty
  a_can_sel_wake: assert property (p_can_sel_wake) else $error("selective wake moved");

  property p_can_keep_low;
    (enter_sleep || enter_stop) && !can_mode[1] && !soft_reset && !enter_failsafe && !wr_ok
      |=> can_mode == $past(can_mode);
  endproperty
  a_can_keep_low: assert property (p_can_keep_low) else $error("off or wake changed");

  property p_sleep_system_error_flag;
    enter_sleep && system_error_flag && !soft_reset && !enter_failsafe && !wr_ok
      |=> can_mode == $past(can_mode);
  endproperty
  a_sleep_system_error_flag: assert property (p_sleep_system_error_flag) else $error("sleep moved can");

  property p_fs_keep;
    enter_failsafe && !soft_reset && !wr_ok
      |=> lin_fast_prog == $past(lin_fast_prog) && lin_low_slope == $past(lin_low_slope)
      && lin_tx_timeout_enable == $past(lin_tx_timeout_enable)
      && int_global == $past(int_global) && st.wke[5] == $past(st.wke[5]);
  endproperty
  a_fs_keep: assert property (p_fs_keep) else $error("fail-safe touched kept bits");

  property p_peak_write;
    wr_ok && wr_addr == ADDR_BUS_CONTROL_TWO && peak_writable && !soft_reset
      |=> main_reg_peak_threshold == $past(wr_data[BUS2_PEAK_TH]);
  endproperty
  a_peak_write: assert property (p_peak_write) else $error("peak bit not written");

  property p_int_global;
    wr_ok && wr_addr == ADDR_WAKE_EXT_CONTROL && !soft_reset
      |=> int_global == $past(wr_data[WKE_INT_GLOBAL]);
  endproperty
  a_int_global: assert property (p_int_global) else $error("interrupt mode lost");

  property p_reserved_wake;
    ((st.wki & ~MASK_WKI) == 8'h00) && ((st.wke & ~MASK_WKE) == 8'h00);
  endproperty
  a_reserved_wake: assert property (p_reserved_wake) else $error("reserved wake bit");

endmodule
`default_nettype wire

// file: dv/sbcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbcr_host_model
  import sbcr_pkg::*;
(
  // clock
  input wire logic core_clk,
  // spi master pins
  output logic spi_select_low,
  output logic spi_sclk,
  output logic spi_mosi,
  input wire logic spi_miso
);
  initial begin
    spi_select_low = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // sclk phases of 4 cycles keep well above the 1-cycle minimum of the sampler
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d,
                      input int nbits, output logic [7:0] rd);
    logic [15:0] f;
    f = {wr, a, d};
    if (wr && a == ADDR_WATCHDOG_CONTROL) f[7] = ^d[6:0];
    rd = 8'h00;
    spi_select_low = 1'b0;
    tick(2);
    for (int i = 15; i > 15 - nbits; i--) begin
      spi_mosi = f[i];
      tick(4);
      if (i < 8) rd[i] = spi_miso;
      spi_sclk = 1'b1;
      tick(4);
      spi_sclk = 1'b0;
    end
    tick(2);
    spi_select_low = 1'b1;
    // a released data line must not look like it still holds the last bit
    spi_mosi = ~spi_mosi;
    tick(3);
  endtask
endmodule
`default_nettype wire

// file: dv/tb_sbcr_watchdog_bus_ctrl_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sbcr_watchdog_bus_ctrl_regs import sbcr_pkg::*;;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel_n, sclk, mosi, miso, wl;
  logic serr = 1'b0;
  logic [2:0] mode = SBCR_MODE_NORMAL;
  logic [5:0] ev = '0;
  logic fo, avc, als, alss, wwin, wbus, wstop, wlong, lfast, llow, ltxd, peak, intg;
  logic [2:0] wper, can;
  logic [1:0] lin;
  logic [7:0] v;
  int error_cnt = 0;
  int comparisons = 0;
  always #2 core_clk = ~core_clk;
  sbcr_host_model u_host (.core_clk(core_clk), .spi_select_low(sel_n), .spi_sclk(sclk),
    .spi_mosi(mosi), .spi_miso(miso));
  sbcr_regs u_dut (.core_clk(core_clk), .rst_n(rst_n), .spi_select_low(sel_n),
    .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso), .dev_mode(mode),
    .system_error_flag(serr), .enter_sleep(ev[0]), .enter_stop(ev[1]),
    .enter_restart(ev[2]), .enter_failsafe(ev[3]), .soft_reset(ev[4]),
    .bus_wake_in_stop(ev[5]), .failure_outputs(fo), .aux_reg_voltage_cfg(avc),
    .aux_reg_load_share(als), .aux_load_share_stop_on(alss), .wdog_window_select(wwin),
    .wdog_start_on_bus_wake(wbus), .wdog_period(wper), .wdog_stop_off(wstop),
    .wdog_long_open_start(wlong), .lin_fast_prog(lfast), .lin_low_slope(llow),
    .lin_tx_timeout_enable(ltxd), .lin_mode_field(lin), .can_mode(can),
    .main_reg_peak_threshold(peak), .int_global(intg));
  function automatic logic [7:0] b8(input logic x);
    return {7'h00, x};
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d, 16, v);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    u_host.xfer(1'b0, a, 8'h00, 16, v);
    chk("readback", v, e);
  endtask
  // index: 0 sleep, 1 stop, 2 restart, 3 fail-safe, 4 soft reset, 5 bus wake
  task automatic pulse(input int k);
    ev[k] = 1'b1;
    @(posedge core_clk);
    #1 ev[k] = 1'b0;
    wl = wlong;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic t_reset;
    rd_chk(ADDR_HW_CONTROL, 8'h00);
    rd_chk(ADDR_WATCHDOG_CONTROL, 8'h14);
    rd_chk(ADDR_BUS_CONTROL_ONE, 8'h20);
    rd_chk(7'h7f, 8'h00);
  endtask
  task automatic t_wdog;
    logic [7:0] d;
    for (int i = 0; i < 7; i++) begin
      d = {2'b00, i[0], i[1], 1'b1, i[2:0]};
      wr(ADDR_WATCHDOG_CONTROL, d);
      rd_chk(ADDR_WATCHDOG_CONTROL, {^d[6:0], d[6:4], 1'b0, d[2:0]});
      chk("period", {5'h00, wper}, {5'h00, d[2:0]});
      chk("window", b8(wwin), b8(d[5]));
      chk("bus_wake_en", b8(wbus), b8(d[4]));
      pulse(5);
      chk("long_open", b8(wl), b8(d[4]));
    end
    wr(ADDR_WATCHDOG_CONTROL, 8'h40);
    wr(ADDR_WAKE_INT_CONTROL, 8'h00);
    chk("stop_off", b8(wstop), 8'h00);
    wr(ADDR_WAKE_INT_CONTROL, 8'h04);
    chk("stop_off", b8(wstop), 8'h01);
    wr(ADDR_WATCHDOG_CONTROL, 8'h00);
    chk("stop_off", b8(wstop), 8'h00);
  endtask
  task automatic t_bus1;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {i[0], ~i[0], i[1], i[1:0], i[2:0]};
      fork
        wr(ADDR_BUS_CONTROL_ONE, d);
        begin
          @(posedge sel_n);
          chk("slope_old", b8(llow), b8(i[0]));
          repeat (2) @(posedge core_clk);
          #1 chk("slope_new", {lfast, llow, 6'h00}, {d[7:6], 6'h00});
        end
      join
      rd_chk(ADDR_BUS_CONTROL_ONE, d);
      chk("modes", {ltxd, lin, can, 2'b00}, {d[5:0], 2'b00});
    end
  endtask
  task automatic t_mode_change;
    logic [2:0] e;
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_BUS_CONTROL_ONE, {5'h00, i[2:0]});
      pulse(i[3]);
      e = (!i[3] && i[1]) ? {i[2], 2'b01} : i[2:0];
      chk("can_mode", {5'h00, can}, {5'h00, e});
    end
    serr = 1'b1;
    wr(ADDR_BUS_CONTROL_ONE, 8'h03);
    pulse(0);
    chk("can_system_error_flag", {5'h00, can}, 8'h03);
    serr = 1'b0;
  endtask
  task automatic t_failsafe;
    wr(ADDR_BUS_CONTROL_ONE, 8'hff);
    wr(ADDR_WAKE_EXT_CONTROL, 8'hb8);
    chk("int_global", b8(intg), 8'h01);
    pulse(3);
    rd_chk(ADDR_BUS_CONTROL_ONE, 8'he9);
    rd_chk(ADDR_WAKE_EXT_CONTROL, 8'ha7);
  endtask
  task automatic t_peak;
    wr(ADDR_BUS_CONTROL_TWO, 8'hff);
    rd_chk(ADDR_BUS_CONTROL_TWO, 8'h20);
    chk("peak", b8(peak), 8'h01);
    mode = SBCR_MODE_STOP;
    wr(ADDR_BUS_CONTROL_TWO, 8'h00);
    rd_chk(ADDR_BUS_CONTROL_TWO, 8'h20);
    mode = SBCR_MODE_INIT;
    wr(ADDR_BUS_CONTROL_TWO, 8'h00);
    rd_chk(ADDR_BUS_CONTROL_TWO, 8'h00);
    mode = SBCR_MODE_NORMAL;
    // a frame one bit short must not commit
    u_host.xfer(1'b1, ADDR_BUS_CONTROL_TWO, 8'hff, 15, v);
    rd_chk(ADDR_BUS_CONTROL_TWO, 8'h00);
  endtask
  task automatic t_restart;
    wr(ADDR_HW_CONTROL, 8'hff);
    rd_chk(ADDR_HW_CONTROL, 8'hfb);
    chk("failure_output_sw_on", b8(fo), 8'h01);
    chk("aux", {5'h00, avc, als, alss}, 8'h07);
    pulse(2);
    chk("fo_off", b8(fo), 8'h00);
    pulse(4);
    rd_chk(ADDR_HW_CONTROL, 8'h88);
    chk("aux_kept", {5'h00, avc, als, alss}, 8'h06);
    rd_chk(ADDR_WATCHDOG_CONTROL, 8'h14);
  endtask
  task automatic close_out;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    t_reset;
    t_wdog;
    t_bus1;
    t_mode_change;
    t_failsafe;
    t_peak;
    t_restart;
    close_out;
  end
  // about 75 frames of some 140 cycles each; four times that is ample
  initial begin
    #160000;
    error_cnt++;
    close_out;
  end
endmodule
`default_nettype wire
